/* File: rtl/acrc_ctrl.sv */
// acrc_ctrl.sv: control logic of an 8-bit successive-approximation converter
// assumes: AXI4-Lite master on ref_clk, comparator and rc clock from the analog side
// How it works
// - the conversion clock is the system clock over 32, 4, 16 or 64, or the rc clock for codes 011 and 111.
// - unimplemented bits of the second control register always read zero.
// - reference field 0x picks the supply and 10 picks the external reference input.
// - the 8-bit result register is read/write and has no defined reset content.
// - the hold capacitor is never discharged after a conversion.
// - setting the start flag begins a conversion; it reads one until hardware clears it at the end.
// - channel codes 0 to 13 pick inputs, 1110 is reserved, 1111 picks the fixed internal reference.
// - with enable clear the converter is held off with no current; setting it enables it.
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "acrc_params.svh"
`default_nettype none
module acrc_ctrl (
	input wire logic ref_clk, // system clock, 40 MHz
	input wire logic rst_b, // asynchronous reset, active low
	input wire logic rc_clk_in, // dedicated rc oscillator, asynchronous
	input wire logic cmp_in, // comparator output, asynchronous
	input wire logic [5:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [5:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output acrc_pkg::acrc_afe_t afe_ctrl, // analog front end commands
	output logic [7:0] dac_code, // trial code to the capacitor array
	output logic irq // level interrupt
);
	import acrc_pkg::*;

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] off);
		addr_hit = (a[5:2] == off[5:2]);
	endfunction : addr_hit

	// rc codes never use the divider; unused codes 000 and 001 run as over 32
	function automatic logic [6:0] div_of(input logic [2:0] cs);
		case (cs)
			`ACRC_CS_DIV4: div_of = `ACRC_DIV4_LEN;
			`ACRC_CS_DIV16: div_of = `ACRC_DIV16_LEN;
			`ACRC_CS_DIV32: div_of = `ACRC_DIV32_LEN;
			`ACRC_CS_DIV64: div_of = `ACRC_DIV64_LEN;
			default: div_of = `ACRC_DIV32_LEN;
		endcase
	endfunction : div_of

	// ------------------------------------------------
	// synchronisers
	// ------------------------------------------------
	logic [2:0] rc_sync_q, rc_sync_d;
	logic [1:0] cmp_sync_q, cmp_sync_d;
	// rc clock sampled as a level; third stage only feeds the edge detect
	always_comb begin
		rc_sync_d = {rc_sync_q[1:0], rc_clk_in};
		cmp_sync_d = {cmp_sync_q[0], cmp_in};
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rc_sync_q <= 3'h0;
			cmp_sync_q <= 2'h0;
		end else begin
			rc_sync_q <= rc_sync_d;
			cmp_sync_q <= cmp_sync_d;
		end
	end

	// ------------------------------------------------
	// registers, bus slave, converter
	// ------------------------------------------------
	logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, result_q, result_d, sar_q, sar_d;
	logic [1:0] sts_q, sts_d, mask_q, mask_d;
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, ws_q, ws_d;
	logic [5:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rdata_q, rdata_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [6:0] div_q, div_d;
	logic [3:0] tick_q, tick_d;
	logic [2:0] bit_q, bit_d;
	acrc_state_t st_q, st_d;
	acrc_afe_t afe_q, afe_d;
	logic [7:0] dac_q, dac_d;
	logic irq_q, irq_d;
	logic do_wr, conv_tick, rc_mode, done;
	logic [2:0] cs;

	always_comb begin
		// bus channels: address and data accepted in either order
		aw_d = aw_q;
		w_d = w_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		bresp_d = bresp_q;
		rv_d = rv_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		ctrl0_d = ctrl0_q;
		ctrl1_d = ctrl1_q;
		result_d = result_q;
		sts_d = sts_q;
		mask_d = mask_q;
		st_d = st_q;
		div_d = div_q;
		tick_d = tick_q;
		bit_d = bit_q;
		sar_d = sar_q;
		done = 1'b0;
		if (s_axi_awvalid && !aw_q) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q) begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb[0]; // strobe is payload: gone once the data is taken
		end
		do_wr = aw_q && w_q && !bv_q;
		if (s_axi_bvalid && s_axi_bready) bv_d = 1'b0;
		// converter clock: divider of ref_clk or rising edge of the synced rc clock
		cs = ctrl1_q[`ACRC_CS_LSB +: 3];
		rc_mode = (cs == `ACRC_CS_RC_A) || (cs == `ACRC_CS_RC_B);
		conv_tick = 1'b0;
		if (st_q == ACRC_CONV) begin
			if (rc_mode) begin
				conv_tick = rc_sync_q[1] && !rc_sync_q[2];
			end else if (div_q == 7'h01) begin
				conv_tick = 1'b1;
				div_d = div_of(cs);
			end else begin
				div_d = div_q - 7'h01;
			end
		end
		// conversion: one tick samples, then eight bit trials msb first
		case (st_q)
			ACRC_IDLE: begin
				if (ctrl0_q[`ACRC_GO_BIT] && ctrl0_q[`ACRC_EN_BIT]) begin
					st_d = ACRC_CONV;
					div_d = div_of(cs);
					tick_d = 4'h0;
					bit_d = 3'h7;
					sar_d = 8'h80;
				end else if (ctrl0_q[`ACRC_GO_BIT]) begin
					ctrl0_d[`ACRC_GO_BIT] = 1'b0; // disabled converter cannot start
				end
			end
			ACRC_CONV: begin
				if (!ctrl0_q[`ACRC_EN_BIT]) begin
					st_d = ACRC_IDLE; // abort, flag drops, result untouched
					ctrl0_d[`ACRC_GO_BIT] = 1'b0;
				end else if (conv_tick) begin
					tick_d = tick_q + 4'h1;
					if (tick_q != 4'h0) begin
						// keep bit if comparator says input above trial
						sar_d[bit_q] = cmp_sync_q[1];
						if (bit_q != 3'h0) sar_d[bit_q - 3'h1] = 1'b1;
						bit_d = bit_q - 3'h1;
					end
					if (tick_q == `ACRC_CONV_TICKS - 4'h1) begin
						st_d = ACRC_IDLE;
						done = 1'b1;
						ctrl0_d[`ACRC_GO_BIT] = 1'b0;
						result_d = {sar_q[7:1], cmp_sync_q[1]}; // same cycle as flag clear
					end
				end
			end
			default: st_d = ACRC_IDLE;
		endcase
		// register writes; software cannot clear the start flag mid conversion
		if (do_wr) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			bresp_d = `ACRC_RESP_OKAY;
			if (!ws_q) begin
				bresp_d = `ACRC_RESP_OKAY; // low byte lane off: write ignored
			end else if (addr_hit(awa_q, `ACRC_OFF_CTRL0)) begin
				ctrl0_d = wd_q[7:0] & `ACRC_CTRL0_MASK;
				if (st_d == ACRC_CONV) ctrl0_d[`ACRC_GO_BIT] = 1'b1; // start cycle included
			end else if (addr_hit(awa_q, `ACRC_OFF_CTRL1)) begin
				ctrl1_d = wd_q[7:0] & `ACRC_CTRL1_MASK;
			end else if (addr_hit(awa_q, `ACRC_OFF_RESULT)) begin
				if (!done) result_d = wd_q[7:0];
			end else if (addr_hit(awa_q, `ACRC_OFF_STATUS)) begin
				sts_d = sts_q & ~wd_q[1:0];
			end else if (addr_hit(awa_q, `ACRC_OFF_MASK)) begin
				mask_d = wd_q[1:0];
			end else begin
				bresp_d = `ACRC_RESP_SLVERR;
			end
		end
		// status: bit0 conversion done, bit1 start refused while disabled; set wins
		if (done) sts_d[0] = 1'b1;
		if (st_q == ACRC_IDLE && ctrl0_q[`ACRC_GO_BIT] && !ctrl0_q[`ACRC_EN_BIT]) sts_d[1] = 1'b1;
		// reads
		if (s_axi_rvalid && s_axi_rready) rv_d = 1'b0;
		if (s_axi_arvalid && !rv_q) begin
			rv_d = 1'b1;
			rresp_d = `ACRC_RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (addr_hit(s_axi_araddr, `ACRC_OFF_CTRL0)) rdata_d[7:0] = ctrl0_q;
			else if (addr_hit(s_axi_araddr, `ACRC_OFF_CTRL1)) rdata_d[7:0] = ctrl1_q & `ACRC_CTRL1_MASK;
			else if (addr_hit(s_axi_araddr, `ACRC_OFF_RESULT)) rdata_d[7:0] = result_q;
			else if (addr_hit(s_axi_araddr, `ACRC_OFF_STATUS)) rdata_d[1:0] = sts_q;
			else if (addr_hit(s_axi_araddr, `ACRC_OFF_MASK)) rdata_d[1:0] = mask_q;
			else rresp_d = `ACRC_RESP_SLVERR;
		end
		// analog front end; no discharge step exists between conversions
		afe_d.power_on = ctrl0_q[`ACRC_EN_BIT];
		afe_d.sample = ctrl0_q[`ACRC_EN_BIT] && !(st_q == ACRC_CONV && tick_q != 4'h0);
		afe_d.use_ext_ref = (ctrl1_q[`ACRC_REF_LSB +: 2] == 2'h2); // 0x supply, 10 external
		afe_d.channel = ctrl0_q[`ACRC_CHAN_LSB +: 4]; // 1111 fixed ref, 1110 reserved
		dac_d = sar_d;
		irq_d = |(sts_d & mask_d);
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 6'h00;
			wd_q <= 32'h0000_0000;
			ws_q <= 1'b0;
			bv_q <= 1'b0;
			bresp_q <= 2'h0;
			rv_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
			ctrl0_q <= 8'h00;
			ctrl1_q <= 8'h00;
			result_q <= 8'h00; // value is undefined to software
			sts_q <= 2'h0;
			mask_q <= 2'h0;
			st_q <= ACRC_IDLE;
			div_q <= 7'h00;
			tick_q <= 4'h0;
			bit_q <= 3'h0;
			sar_q <= 8'h00;
			afe_q <= '0;
			dac_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			bresp_q <= bresp_d;
			rv_q <= rv_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl0_q <= ctrl0_d;
			ctrl1_q <= ctrl1_d;
			result_q <= result_d;
			sts_q <= sts_d;
			mask_q <= mask_d;
			st_q <= st_d;
			div_q <= div_d;
			tick_q <= tick_d;
			bit_q <= bit_d;
			sar_q <= sar_d;
			afe_q <= afe_d;
			dac_q <= dac_d;
			irq_q <= irq_d;
		end
	end

	// ------------------------------------------------
	// outputs, all from flip-flops
	// ------------------------------------------------
	always_comb begin
		s_axi_awready = !aw_q;
		s_axi_wready = !w_q;
		s_axi_bvalid = bv_q;
		s_axi_bresp = bresp_q;
		s_axi_arready = !rv_q;
		s_axi_rvalid = rv_q;
		s_axi_rdata = rdata_q;
		s_axi_rresp = rresp_q;
		afe_ctrl = afe_q;
		dac_code = dac_q;
		irq = irq_q;
	end
endmodule : acrc_ctrl
`default_nettype wire

/* File: rtl/acrc_params.svh */
// acrc_params.svh: register offsets, field positions, field masks, codes and timing counts
// assumes: included by the control module, the checker and the bench, 40 MHz ref_clk
`ifndef ACRC_PARAMS_SVH
`define ACRC_PARAMS_SVH
// byte addresses of the word registers
`define ACRC_OFF_CTRL0 6'h00
`define ACRC_OFF_CTRL1 6'h04
`define ACRC_OFF_RESULT 6'h08
`define ACRC_OFF_STATUS 6'h0C
`define ACRC_OFF_MASK 6'h10
// first control register fields
`define ACRC_EN_BIT 0
`define ACRC_GO_BIT 1
`define ACRC_CHAN_LSB 2
`define ACRC_CTRL0_MASK 8'h3F
// second control register fields
`define ACRC_REF_LSB 0
`define ACRC_CS_LSB 4
`define ACRC_CTRL1_MASK 8'h73
// clock select codes
`define ACRC_CS_DIV32 3'h2
`define ACRC_CS_DIV4 3'h4
`define ACRC_CS_DIV16 3'h5
`define ACRC_CS_DIV64 3'h6
`define ACRC_CS_RC_A 3'h3
`define ACRC_CS_RC_B 3'h7
// divider lengths in ref_clk cycles per converter clock
`define ACRC_DIV4_LEN 7'h04
`define ACRC_DIV16_LEN 7'h10
`define ACRC_DIV32_LEN 7'h20
`define ACRC_DIV64_LEN 7'h40
// channel codes
`define ACRC_CHAN_RESERVED 4'hE
`define ACRC_CHAN_FIXED 4'hF
// conversion length in converter clock periods: eight bits plus one
`define ACRC_CONV_TICKS 4'h9
`define ACRC_RESP_OKAY 2'h0
`define ACRC_RESP_SLVERR 2'h2
`endif

/* File: rtl/acrc_pkg.sv */
// acrc_pkg.sv: types shared by the converter control block
// assumes: nothing beyond the params header
`default_nettype none
package acrc_pkg;
	// analog front end command bundle
	typedef struct packed {
		logic power_on;
		logic sample;
		logic use_ext_ref;
		logic [3:0] channel;
	} acrc_afe_t;
	typedef enum logic [1:0] {
		ACRC_IDLE,
		ACRC_CONV
	} acrc_state_t;
endpackage : acrc_pkg
`default_nettype wire

/* File: verif/acrc_ctrl_assertions.sv */
// acrc_ctrl_assertions.sv: port checks for the converter control block
// assumes: bound to acrc_ctrl, one clock, async active-low reset
`include "acrc_params.svh"
`default_nettype none
module acrc_ctrl_assertions (
	input wire logic ref_clk, // clock
	input wire logic rst_b, // reset
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic [5:0] s_axi_araddr, // ar address
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r response
	input wire logic s_axi_rvalid, // r valid
	input wire acrc_pkg::acrc_afe_t afe_ctrl // front end
);
	import acrc_pkg::*;
	logic [5:0] rd_addr_q;
	logic [5:0] rd_addr_d;
	// ----------------------------------------
	// read address tracking
	// ----------------------------------------
	// keeps the address of the read in flight so data can be judged
	always_comb begin
		rd_addr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_q;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_addr_q <= 6'h00;
		end else begin
			rd_addr_q <= rd_addr_d;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_taken and !s_axi_bvalid |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answered twice");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_ctrl1_pad: assert property (s_axi_rvalid && rd_addr_q == `ACRC_OFF_CTRL1 |->
		s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[3:2] == 2'h0)
		else $error("unimplemented bits not zero");
	a_result_byte: assert property (s_axi_rvalid && rd_addr_q == `ACRC_OFF_RESULT |->
		s_axi_rdata[31:8] == 24'h0)
		else $error("result wider than a byte");
	a_off_quiet: assert property (!afe_ctrl.power_on |-> !afe_ctrl.sample)
		else $error("sampling while disabled");
	a_unmapped_err: assert property (s_axi_rvalid && rd_addr_q > (`ACRC_OFF_MASK | 6'h03) |->
		s_axi_rresp == `ACRC_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule : acrc_ctrl_assertions
bind acrc_ctrl acrc_ctrl_assertions u_chk (.ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .afe_ctrl);
`default_nettype wire

/* File: verif/acrc_ctrl_bench.sv */
// acrc_ctrl_bench.sv: directed bench for the converter control block
// assumes: design and checker compiled first, 40 MHz ref_clk
`include "acrc_params.svh"
`default_nettype none
module acrc_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import acrc_pkg::*;
	localparam int ACQ_CYC = 8; // nominal acquisition wait
	logic ref_clk, rst_b, rc_clk_in, cmp_in, irq;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [7:0] dac_code;
	acrc_afe_t afe_ctrl;
	int mismatches = 0;
	int checks_done = 0;
	acrc_ctrl u_dut (.ref_clk, .rst_b, .rc_clk_in, .cmp_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .afe_ctrl, .dac_code, .irq);
	// ----------------------------------------
	// clocks and helpers
	// ----------------------------------------
	// rc period is not a multiple of ref_clk, so phases drift
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		rc_clk_in = 1'b0;
		forever #97 rc_clk_in = ~rc_clk_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic give_up(input bit out);
		if (out) begin
			mismatches++;
			tally_and_finish();
		end
	endtask : give_up
	// bus tasks start just after a rising edge and end one edge after release
	task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		give_up(n == 99);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask : axw
	task automatic axr(input logic [5:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		give_up(n == 99);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask : axr
	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		axr(a);
		chk(rd, exp);
	endtask : rdchk
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ctrl1;
		rdchk(`ACRC_OFF_CTRL1, 32'h0);
		axw(`ACRC_OFF_CTRL1, 32'hFFFF_FFFF, rs);
		rdchk(`ACRC_OFF_CTRL1, 32'h73);
		for (int i = 0; i < 3; i++) begin
			axw(`ACRC_OFF_CTRL1, i, rs);
			repeat (2) @(posedge ref_clk);
			chk(afe_ctrl.use_ext_ref, i == 2);
		end
		$display("test ctrl1 done");
	endtask : t_ctrl1
	task automatic t_chan;
		logic [3:0] c [4] = '{4'h0, 4'hD, 4'hE, 4'hF};
		foreach (c[i]) begin
			axw(`ACRC_OFF_CTRL0, {c[i], 2'b01}, rs);
			repeat (2) @(posedge ref_clk);
			chk(afe_ctrl.channel, c[i]);
			chk(afe_ctrl.power_on, 1'b1);
		end
		axw(`ACRC_OFF_CTRL0, 32'h0, rs);
		repeat (2) @(posedge ref_clk);
		chk(afe_ctrl.power_on, 1'b0);
		$display("test channel done");
	endtask : t_chan
	task automatic t_result;
		axw(`ACRC_OFF_RESULT, 32'hA5, rs);
		rdchk(`ACRC_OFF_RESULT, 32'hA5);
		s_axi_wstrb <= 4'h0;
		axw(`ACRC_OFF_RESULT, 32'h3C, rs);
		chk(rs, `ACRC_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rdchk(`ACRC_OFF_RESULT, 32'hA5);
		rdchk(6'h14, 32'h0);
		chk(rs, `ACRC_RESP_SLVERR);
		$display("test result done");
	endtask : t_result
	// refused start raises status bit one, which only the mask lets out
	task automatic t_irq;
		axw(`ACRC_OFF_MASK, 32'h1, rs);
		axw(`ACRC_OFF_CTRL0, 32'h2, rs);
		rdchk(`ACRC_OFF_CTRL0, 32'h0);
		rdchk(`ACRC_OFF_STATUS, 32'h2);
		chk(irq, 1'b0);
		axw(`ACRC_OFF_MASK, 32'h3, rs);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b1);
		axw(`ACRC_OFF_STATUS, 32'h2, rs);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		$display("test interrupt done");
	endtask : t_irq
	// duration window tells the divider apart; cmp level fixes the code
	task automatic t_conv(input logic [2:0] cs, input int n);
		realtime t0;
		int cyc;
		cmp_in <= cs[0];
		axw(`ACRC_OFF_CTRL1, {cs, 4'h0}, rs);
		axw(`ACRC_OFF_CTRL0, 32'h1, rs);
		repeat (ACQ_CYC) @(posedge ref_clk);
		t0 = $realtime;
		axw(`ACRC_OFF_CTRL0, 32'h3, rs);
		rdchk(`ACRC_OFF_CTRL0, 32'h3);
		for (cyc = 0; cyc < 999 && irq !== 1'b1; cyc++) @(posedge ref_clk);
		give_up(cyc == 999);
		cyc = int'(($realtime - t0) / 25.0);
		chk(cyc >= 7 * n && cyc <= 10 * n + 24, 1'b1);
		rdchk(`ACRC_OFF_CTRL0, 32'h1);
		rdchk(`ACRC_OFF_RESULT, {24'h0, {8{cs[0]}}});
		chk(dac_code, {8{cs[0]}});
		chk(afe_ctrl.sample, 1'b1);
		rdchk(`ACRC_OFF_STATUS, 32'h1);
		axw(`ACRC_OFF_STATUS, 32'h1, rs);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		$display("test clock select %0d done", cs);
	endtask : t_conv
	initial begin
		{rst_b, cmp_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		t_ctrl1();
		t_chan();
		t_result();
		t_irq();
		t_conv(`ACRC_CS_DIV4, 4);
		t_conv(`ACRC_CS_DIV16, 16);
		t_conv(`ACRC_CS_DIV32, 32);
		t_conv(`ACRC_CS_DIV64, 64);
		t_conv(`ACRC_CS_RC_A, 8);
		t_conv(`ACRC_CS_RC_B, 8);
		tally_and_finish();
	end
endmodule : acrc_ctrl_bench
`default_nettype wire
